// >>> core/rsc_ctrl.sv
// What this block does
// - any of power-on, brownout, watchdog-reset, enabled pin, debugger bit starts system reset.
// - in stop mode, watchdog time-out or enabled pin change starts stop recovery.
// - hold reset 66 oscillator cycles, or 5000 with crystal enabled.
// - stop recovery resets CPU, touching only watchdog and clock control registers.
// - power-on and brownout delay counts only after supply passes threshold.
// - pin still low when delay ends keeps reset until release.
// - reset start makes pins inputs without pull-ups; reset pin becomes open-drain.
// - reset pin driven low during supply wait and hold delay; software may later repurpose it.
// - CPU and peripherals idle in reset; oscillators keep running.
// - control registers take reset values; pointers, flags and RAM stay undefined.
// - leaving reset, fetch vector from bytes 0002h and 0003h into program counter.
// - after system reset the internal precision clock source is selected.
// - pin pulses under four clock cycles are ignored in normal or halt.
// - debugger reset resets all but the debugger itself.
// - power-on or brownout recovery sets the power-on cause flag.
// - brownout holds reset while supply low, then runs full power-on sequence.
// - option bit decides whether brownout monitor stays on in stop mode.
// - watchdog time-out resets when option bit is 1, else raises interrupt.
// - watchdog reset sets the watchdog cause flag.
// - reading the cause register clears its upper four bits.
// - pin-caused reset sets the pin cause flag.
// - any stop recovery sets the stop cause flag.
//
// Purpose: reset sequencer, cause register and reset pin control
// Assumes: i_mclk is the internal precision clock; option bits are static levels
// Notes:   register port: read data valid the cycle after the read strobe
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module rsc_ctrl
	import rsc_pkg::*;
#(
	parameter int HOLD_LONG = RSC_HOLD_LONG // crystal hold count, shortenable
) (
	input  wire logic        i_mclk,            // system clock
	input  wire logic        i_reset_n,         // async reset
	input  wire logic        i_por_n,           // power-on monitor, low = supply below threshold
	input  wire logic        i_brownout,        // brownout monitor, high = supply low
	input  wire logic        i_supply_ok,       // supply above power-on threshold
	input  wire logic        i_wdt_timeout,     // watchdog time-out pulse
	input  wire logic        i_wdt_reset_sel,   // watchdog_reset_select_option
	input  wire logic        i_brownout_keep_on,// brownout_keep_on_option
	input  wire logic        i_xtal_en,         // crystal enabled option
	input  wire logic        i_pin_reset_en,    // alternate reset function enabled
	input  wire logic        i_stop_mode,       // CPU in stop mode
	input  wire logic [7:0]  i_gpio,            // raw port pins
	input  wire logic [7:0]  i_gpio_smr_en,     // pins enabled as recovery sources
	input  wire logic        i_rst_pin,         // shared_reset_port_pin level
	input  wire logic [15:0] i_pmem_data,       // program memory byte in low bits
	input  wire logic        i_wr,              // register write strobe
	input  wire logic        i_rd,              // register read strobe
	input  wire logic [1:0]  i_addr,            // register index
	input  wire logic [7:0]  i_wdata,           // write data
	output logic      [7:0]  o_rdata,           // read data
	output logic             o_rst_pin_out,     // reset pin output level (always 0)
	output logic             o_rst_pin_oe,      // reset pin drive enable
	output logic             o_gpio_reset,      // port configs to input, pull-ups off
	output logic             o_cpu_reset,       // CPU held
	output logic             o_periph_reset,    // peripherals held (system reset only)
	output logic             o_dbg_keep,        // debugger not reset in this reset
	output logic             o_brownout_en,     // brownout monitor enable
	output logic             o_wdt_irq,         // watchdog interrupt pulse
	output logic      [15:0] o_pmem_addr,       // vector fetch address
	output logic      [15:0] o_pc,              // program counter load value
	output logic             o_pc_load,         // pulse: load program counter
	output logic      [7:0]  o_watchdog_control_reg,         // watchdog_control_reg
	output logic      [7:0]  o_clk_ctl          // clock_source_control_reg
);
	logic        pin_s;
	logic        rst_pin_low;
	logic        pin_req;
	logic [7:0]  gpio_s;
	logic [7:0]  gpio_prev_q;
	rsc_state_type st_q, st_d;
	logic [RSC_CNT_W-1:0] cnt_q, cnt_d;
	logic        sys_q, sys_d;       // current reset is a system reset
	logic [7:0]  cause_q, cause_d;
	logic [7:0]  wdtctl_q, wdtctl_d;
	logic [7:0]  clkctl_q, clkctl_d;
	logic [7:0]  dbgctl_q, dbgctl_d;
	logic [7:0]  rdata_q, rdata_d;
	logic [15:0] pc_q, pc_d;
	logic        pcld_q, pcld_d;
	logic        irq_q, irq_d;
	logic        dbgkeep_q, dbgkeep_d;
	logic        cpu_q, per_q, drv_q, bo_q, gpr_q;
	logic [15:0] paddr_q, paddr_d;
	rsc_src_type src;
	rsc_bus_type bus;
	logic        any_sys, smr_evt, supply_low;
	logic [RSC_CNT_W-1:0] hold;

	// pins cross into the clock domain first
	rsc_sync #(.W(8), .INI(32'h0)) u_gsync (
		.i_mclk   (i_mclk),
		.i_reset_n(i_reset_n),
		.i_async  (i_gpio),
		.o_sync   (gpio_s)
	);
	rsc_sync #(.W(1), .INI(32'h1)) u_psync (
		.i_mclk   (i_mclk),
		.i_reset_n(i_reset_n),
		.i_async  (i_rst_pin),
		.o_sync   (pin_s)
	);
	assign rst_pin_low = ~pin_s & i_pin_reset_en;

	rsc_pinfilt u_filt (
		.i_mclk   (i_mclk),
		.i_reset_n(i_reset_n),
		.i_pin_low(rst_pin_low),
		.o_pin_req(pin_req)
	);

	// request gathering
	always_comb begin
		bus         = '{rd: i_rd, wr: i_wr, addr: i_addr, wdata: i_wdata};
		supply_low  = ~i_por_n | (i_brownout & (~i_stop_mode | i_brownout_keep_on));
		src.por     = ~i_por_n;
		src.brownout= supply_low & i_por_n;
		src.wdt     = i_wdt_timeout & i_wdt_reset_sel & ~i_stop_mode;
		src.pin_reset_flag     = pin_req;
		src.dbg     = dbgctl_q[RSC_DBG_RST_BIT];
		any_sys     = |src;
		smr_evt     = i_stop_mode & (i_wdt_timeout | |((gpio_s ^ gpio_prev_q) & i_gpio_smr_en));
		hold        = i_xtal_en ? RSC_CNT_W'(HOLD_LONG) : RSC_CNT_W'(RSC_HOLD_SHORT);
	end

	// sequencer and registers, next values
	always_comb begin
		st_d      = st_q;
		cnt_d     = cnt_q;
		sys_d     = sys_q;
		cause_d   = cause_q;
		wdtctl_d  = wdtctl_q;
		clkctl_d  = clkctl_q;
		dbgctl_d  = dbgctl_q;
		rdata_d   = 8'h00;
		pc_d      = pc_q;
		pcld_d    = 1'b0;
		irq_d     = 1'b0;
		dbgkeep_d = dbgkeep_q;
		paddr_d   = paddr_q;
		// register port; read clears upper cause bits
		if (bus.rd) begin
			case (bus.addr)
				RSC_IDX_CAUSE:  rdata_d = cause_q;
				RSC_IDX_DBGCTL: rdata_d = dbgctl_q;
				RSC_IDX_CLKCTL: rdata_d = clkctl_q;
				RSC_IDX_STATE:  rdata_d = {5'h00, 3'(st_q)};
				default:        rdata_d = 8'h00;
			endcase
			if (bus.addr == RSC_IDX_CAUSE)
				cause_d = {4'h0, cause_q[3:0]};
		end
		if (bus.wr) begin
			case (bus.addr)
				RSC_IDX_CAUSE:  wdtctl_d = bus.wdata;
				RSC_IDX_DBGCTL: dbgctl_d = bus.wdata;
				RSC_IDX_CLKCTL: clkctl_d = bus.wdata;
				default: ;
			endcase
		end
		if (i_wdt_timeout & ~i_wdt_reset_sel)
			irq_d = 1'b1;
		case (st_q)
			RSC_ST_RUN: begin
				if (any_sys) begin
					sys_d     = 1'b1;
					dbgkeep_d = src.dbg & ~src.por & ~src.brownout;
					wdtctl_d  = RSC_WDTCTL_RESET;
					clkctl_d  = RSC_CLKCTL_RESET;
					dbgctl_d  = RSC_DBGCTL_RESET;
					cause_d   = 8'h00;
					cause_d[RSC_CAUSE_POR] = src.por | src.brownout | src.dbg;
					cause_d[RSC_CAUSE_WDT] = src.wdt;
					cause_d[RSC_CAUSE_EXT] = src.pin_reset_flag;
					cnt_d     = '0;
					st_d      = (src.por | src.brownout) ? RSC_ST_WAIT_SUPPLY : RSC_ST_HOLD;
				end else if (smr_evt) begin
					sys_d     = 1'b0;
					dbgkeep_d = 1'b1;
					wdtctl_d  = RSC_WDTCTL_RESET;
					clkctl_d  = RSC_CLKCTL_RESET;
					cause_d[RSC_CAUSE_STOP] = 1'b1;
					cause_d[RSC_CAUSE_WDT]  = i_wdt_timeout;
					cnt_d     = '0;
					st_d      = RSC_ST_HOLD;
				end
			end
			RSC_ST_WAIT_SUPPLY: begin
				cnt_d = '0;
				if (i_supply_ok & ~supply_low)
					st_d = RSC_ST_HOLD;
			end
			RSC_ST_HOLD: begin
				if (supply_low) begin
					st_d = RSC_ST_WAIT_SUPPLY;
					cause_d[RSC_CAUSE_POR] = 1'b1;
				end else if (cnt_q >= hold - RSC_CNT_W'(1))
					st_d = RSC_ST_PIN_WAIT;
				else
					cnt_d = cnt_q + RSC_CNT_W'(1);
			end
			RSC_ST_PIN_WAIT: begin
				if (supply_low)
					st_d = RSC_ST_WAIT_SUPPLY;
				else if (!rst_pin_low) begin
					st_d    = RSC_ST_FETCH_HI;
					paddr_d = RSC_VECTOR_HI;
				end
			end
			RSC_ST_FETCH_HI: begin
				pc_d[15:8] = i_pmem_data[7:0];
				paddr_d    = RSC_VECTOR_LO;
				st_d       = RSC_ST_FETCH_LO;
			end
			RSC_ST_FETCH_LO: begin
				pc_d[7:0] = i_pmem_data[7:0];
				pcld_d    = 1'b1;
				sys_d     = 1'b0;
				dbgkeep_d = 1'b0;
				st_d      = RSC_ST_RUN;
			end
			default: st_d = RSC_ST_RUN;
		endcase
	end

	// state registers; cpu idles outside RUN, peripherals only in a system reset
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_q        <= RSC_ST_WAIT_SUPPLY;
			cnt_q       <= '0;
			sys_q       <= 1'b1;
			cause_q     <= RSC_CAUSE_RESET;
			wdtctl_q    <= RSC_WDTCTL_RESET;
			clkctl_q    <= RSC_CLKCTL_RESET;
			dbgctl_q    <= RSC_DBGCTL_RESET;
			rdata_q     <= 8'h00;
			pc_q        <= 16'h0000;
			pcld_q      <= 1'b0;
			irq_q       <= 1'b0;
			dbgkeep_q   <= 1'b0;
			paddr_q     <= 16'h0000;
			gpio_prev_q <= 8'h00;
			cpu_q       <= 1'b1;
			per_q       <= 1'b1;
			drv_q       <= 1'b1;
			gpr_q       <= 1'b1;
			bo_q        <= 1'b1;
		end else begin
			st_q        <= st_d;
			cnt_q       <= cnt_d;
			sys_q       <= sys_d;
			cause_q     <= cause_d;
			wdtctl_q    <= wdtctl_d;
			clkctl_q    <= clkctl_d;
			dbgctl_q    <= dbgctl_d;
			rdata_q     <= rdata_d;
			pc_q        <= pc_d;
			pcld_q      <= pcld_d;
			irq_q       <= irq_d;
			dbgkeep_q   <= dbgkeep_d;
			paddr_q     <= paddr_d;
			gpio_prev_q <= gpio_s;
			cpu_q       <= (st_d != RSC_ST_RUN);
			per_q       <= (st_d != RSC_ST_RUN) & sys_d;
			// pin drive lets go when the delay ends, else pin wait would hear our own low
			drv_q       <= ((st_d == RSC_ST_WAIT_SUPPLY) | (st_d == RSC_ST_HOLD)) & sys_d;
			gpr_q       <= (st_d != RSC_ST_RUN) & sys_d;
			bo_q        <= ~i_stop_mode | i_brownout_keep_on;
		end
	end

	assign o_rdata        = rdata_q;
	assign o_rst_pin_out  = 1'b0;
	assign o_rst_pin_oe   = drv_q;  // open drain, low only
	assign o_gpio_reset   = gpr_q;
	assign o_cpu_reset    = cpu_q;
	assign o_periph_reset = per_q;
	assign o_dbg_keep     = dbgkeep_q;
	assign o_brownout_en  = bo_q;
	assign o_wdt_irq      = irq_q;
	assign o_pmem_addr    = paddr_q;
	assign o_pc           = pc_q;
	assign o_pc_load      = pcld_q;
	assign o_watchdog_control_reg      = wdtctl_q;
	assign o_clk_ctl      = clkctl_q;
endmodule

// >>> core/rsc_pkg.sv
// Purpose: constants and carrier types for the reset and stop recovery controller
// Assumes: 200 MHz system clock stands in for the internal precision oscillator
// Notes:   register index 0 is the cause/watchdog-control word, index 1 the debugger control word
package rsc_pkg;
	localparam logic [1:0]  RSC_IDX_CAUSE     = 2'h0; // cause read / watchdog control write
	localparam logic [1:0]  RSC_IDX_DBGCTL    = 2'h1; // debugger control register
	localparam logic [1:0]  RSC_IDX_CLKCTL    = 2'h2; // clock source control register
	localparam logic [1:0]  RSC_IDX_STATE     = 2'h3; // live controller state
	localparam int          RSC_CAUSE_POR     = 7;
	localparam int          RSC_CAUSE_STOP    = 6;
	localparam int          RSC_CAUSE_WDT     = 5;
	localparam int          RSC_CAUSE_EXT     = 4;
	localparam int          RSC_DBG_RST_BIT   = 0;
	localparam logic [7:0]  RSC_WDTCTL_RESET  = 8'h00;
	localparam logic [7:0]  RSC_CLKCTL_RESET  = 8'hA0; // selects internal precision source
	localparam logic [7:0]  RSC_DBGCTL_RESET  = 8'h00;
	localparam logic [7:0]  RSC_CAUSE_RESET   = 8'h80;
	localparam logic [15:0] RSC_VECTOR_HI     = 16'h0002;
	localparam logic [15:0] RSC_VECTOR_LO     = 16'h0003;
	localparam int          RSC_HOLD_SHORT    = 66;
	localparam int          RSC_HOLD_LONG     = 5000;
	localparam int          RSC_PIN_MIN_CYC   = 4;
	localparam int          RSC_CNT_W         = 13;

	typedef enum logic [2:0] {
		RSC_ST_RUN,
		RSC_ST_WAIT_SUPPLY,
		RSC_ST_HOLD,
		RSC_ST_PIN_WAIT,
		RSC_ST_FETCH_HI,
		RSC_ST_FETCH_LO
	} rsc_state_type;

	typedef struct packed {
		logic por;
		logic brownout;
		logic wdt;
		logic pin_reset_flag;
		logic dbg;
	} rsc_src_type;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [1:0] addr;
		logic [7:0] wdata;
	} rsc_bus_type;
endpackage

// >>> core/rsc_sync.sv
// Purpose: two flip-flop synchroniser for a vector of pin levels
// Assumes: inputs asynchronous to i_mclk
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module rsc_sync #(
	parameter int          W   = 1,
	parameter logic [31:0] INI = 32'h0
) (
	input  wire logic         i_mclk,    // system clock
	input  wire logic         i_reset_n, // async reset
	input  wire logic [W-1:0] i_async,   // raw levels
	output logic      [W-1:0] o_sync     // synchronised levels
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// two-stage capture
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta_q <= INI[W-1:0];
			sync_q <= INI[W-1:0];
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end
	assign o_sync = sync_q;
endmodule

// >>> core/rsc_pinfilt.sv
// Purpose: width filter on the synchronised reset pin
// Assumes: input already synchronised
// Notes:   low for the minimum count of cycles yields a level request
`timescale 1ns/1ps
module rsc_pinfilt
	import rsc_pkg::*;
(
	input  wire logic i_mclk,    // system clock
	input  wire logic i_reset_n, // async reset
	input  wire logic i_pin_low, // synchronised pin low
	output logic      o_pin_req  // pin held low long enough
);
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic       req_q;
	logic       req_d;

	// count consecutive low cycles, drop short pulses
	always_comb begin
		cnt_d = 3'h0;
		req_d = 1'b0;
		if (i_pin_low) begin
			cnt_d = (cnt_q == 3'(RSC_PIN_MIN_CYC)) ? cnt_q : cnt_q + 3'h1;
			req_d = (cnt_d == 3'(RSC_PIN_MIN_CYC));
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt_q <= 3'h0;
			req_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			req_q <= req_d;
		end
	end
	assign o_pin_req = req_q;
endmodule

// >>> tb/rsc_props.sv
// Purpose: concurrent checks on the reset controller ports
// Assumes: one clock domain, async active-low reset
// Notes:   hold_cnt_q counts consecutive cycles with the cpu held
`timescale 1ns/1ps
module rsc_props
	import rsc_pkg::*;
#(
	parameter int HOLD_LONG = RSC_HOLD_LONG // crystal hold count
) (
	input wire logic       i_mclk,          // clock
	input wire logic       i_reset_n,       // async reset
	input wire logic       i_por_n,         // power-on monitor
	input wire logic       i_brownout,      // brownout monitor
	input wire logic       i_stop_mode,     // stop mode
	input wire logic       i_wdt_timeout,   // time-out pulse
	input wire logic       i_wdt_reset_sel, // reset select option
	input wire logic       i_xtal_en,       // crystal option
	input wire logic       i_rst_pin,       // reset pin level
	input wire logic       i_pin_reset_en,  // pin function enable
	input wire logic       o_cpu_reset,     // cpu held
	input wire logic       o_periph_reset,  // peripherals held
	input wire logic       o_rst_pin_oe,    // pin drive enable
	input wire logic       o_rst_pin_out,   // pin drive level
	input wire logic       o_gpio_reset,    // port config reset
	input wire logic       o_wdt_irq,       // time-out interrupt
	input wire logic       o_pc_load,       // program counter load
	input wire logic [7:0] o_clk_ctl        // clock source control
);
	logic [15:0] hold_cnt_q; // cycles held so far
	logic [15:0] hold_cnt_d; // next count
	// count consecutive held cycles
	always_comb begin
		hold_cnt_d = o_cpu_reset ? hold_cnt_q + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			hold_cnt_q <= 16'h0000;
		end else begin
			hold_cnt_q <= hold_cnt_d;
		end
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	// time-out seen while running, split by the option bit
	sequence s_dog_rst; !o_cpu_reset && i_wdt_timeout && i_wdt_reset_sel; endsequence
	sequence s_dog_irq; !o_cpu_reset && i_wdt_timeout && !i_wdt_reset_sel && !i_stop_mode; endsequence
	property p_dog_rst; s_dog_rst |=> o_cpu_reset; endproperty
	a_dog_rst: assert property (p_dog_rst) else $error("time-out did not hold the cpu");
	property p_dog_irq; s_dog_irq |=> o_wdt_irq && !o_cpu_reset; endproperty
	a_dog_irq: assert property (p_dog_irq) else $error("time-out did not raise the interrupt");
	property p_hold; $fell(o_cpu_reset) |-> hold_cnt_q >= (i_xtal_en ? HOLD_LONG : RSC_HOLD_SHORT); endproperty
	a_hold: assert property (p_hold) else $error("cpu released before the hold count");
	property p_pc; $fell(o_cpu_reset) |-> o_pc_load; endproperty
	a_pc: assert property (p_pc) else $error("cpu released without loading the vector");
	property p_pin_hold; o_cpu_reset && !i_rst_pin && i_pin_reset_en |=> o_cpu_reset; endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("cpu released while the pin is low");
	property p_pin_cfg; $rose(o_periph_reset) |-> o_rst_pin_oe && o_gpio_reset && !o_rst_pin_out; endproperty
	a_pin_cfg: assert property (p_pin_cfg) else $error("pins not reconfigured at reset start");
	property p_clk; $fell(o_periph_reset) |-> o_clk_ctl == RSC_CLKCTL_RESET; endproperty
	a_clk: assert property (p_clk) else $error("clock source not reset after system reset");
	property p_supply; !i_por_n || (i_brownout && !i_stop_mode) |-> ##[1:3] o_cpu_reset; endproperty
	a_supply: assert property (p_supply) else $error("low supply did not hold the cpu");
endmodule

// >>> tb/rsc_far.sv
// Purpose: program memory and board wiring around the reset controller
// Assumes: reset pin has a pull-up, memory answers while the address stands
// Notes:   unmapped addresses return a pattern that changes every cycle
`timescale 1ns/1ps
module rsc_far (
	input  wire logic        i_mclk,      // clock
	input  wire logic [15:0] i_pmem_addr, // fetch address
	input  wire logic        i_pin_oe,    // device drives pin
	input  wire logic        i_pin_out,   // device pin level
	input  wire logic        i_board_low, // board pulls pin low
	output logic      [15:0] o_pmem_data, // memory byte
	output logic             o_pin        // resolved pin level
);
	logic [15:0] mem_q = 16'h5A5A; // filler for unmapped addresses
	// filler flips every cycle so a mistimed fetch shows up
	always @(posedge i_mclk) begin
		mem_q <= ~mem_q;
	end
	// vector bytes at their two addresses
	assign o_pmem_data = (i_pmem_addr == 16'h0002) ? 16'h0012 :
		(i_pmem_addr == 16'h0003) ? 16'h0034 : mem_q;
	// open-drain wire with pull-up
	assign o_pin = ((i_pin_oe && !i_pin_out) || i_board_low) ? 1'b0 : 1'b1;
endmodule

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the reset controller
// Assumes: crystal hold shortened to 200 cycles
// Notes:   vector in memory is 1234
`timescale 1ns/1ps
module tb_top;
	import rsc_pkg::*;
	localparam int HOLD_L = 200; // shortened crystal hold
	logic i_mclk = 0, i_reset_n = 0, i_por_n = 1, i_brownout = 0, i_supply_ok = 1, i_wdt_timeout = 0;
	logic i_wdt_reset_sel = 1, i_brownout_keep_on = 0, i_xtal_en = 0, i_pin_reset_en = 1, i_stop_mode = 0;
	logic i_wr = 0, i_rd = 0, board_low = 0, i_rst_pin, o_rst_pin_out, o_rst_pin_oe, o_gpio_reset;
	logic o_cpu_reset, o_periph_reset, o_dbg_keep, o_brownout_en, o_wdt_irq, o_pc_load;
	logic [7:0] i_gpio = 0, i_gpio_smr_en = 8'h01, i_wdata = 0, o_rdata, o_watchdog_control_reg, o_clk_ctl;
	logic [1:0] i_addr = 0;
	logic [15:0] i_pmem_data, o_pmem_addr, o_pc;
	int num_errors = 0, cmp_count = 0, waited;
	always #2.5 i_mclk = ~i_mclk;
	rsc_ctrl #(.HOLD_LONG(HOLD_L)) uut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_por_n(i_por_n),
		.i_brownout(i_brownout), .i_supply_ok(i_supply_ok), .i_wdt_timeout(i_wdt_timeout),
		.i_wdt_reset_sel(i_wdt_reset_sel), .i_brownout_keep_on(i_brownout_keep_on), .i_xtal_en(i_xtal_en),
		.i_pin_reset_en(i_pin_reset_en), .i_stop_mode(i_stop_mode), .i_gpio(i_gpio), .i_gpio_smr_en(i_gpio_smr_en),
		.i_rst_pin(i_rst_pin), .i_pmem_data(i_pmem_data), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
		.i_wdata(i_wdata), .o_rdata(o_rdata), .o_rst_pin_out(o_rst_pin_out), .o_rst_pin_oe(o_rst_pin_oe),
		.o_gpio_reset(o_gpio_reset), .o_cpu_reset(o_cpu_reset), .o_periph_reset(o_periph_reset),
		.o_dbg_keep(o_dbg_keep), .o_brownout_en(o_brownout_en), .o_wdt_irq(o_wdt_irq), .o_pmem_addr(o_pmem_addr),
		.o_pc(o_pc), .o_pc_load(o_pc_load), .o_watchdog_control_reg(o_watchdog_control_reg), .o_clk_ctl(o_clk_ctl));
	rsc_far u_far (.i_mclk(i_mclk), .i_pmem_addr(o_pmem_addr), .i_pin_oe(o_rst_pin_oe), .i_pin_out(o_rst_pin_out),
		.i_board_low(board_low), .o_pmem_data(i_pmem_data), .o_pin(i_rst_pin));
	// compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// register port cycles
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_wr <= 1; i_addr <= a; i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge i_mclk);
		i_rd <= 1; i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 0;
		@(posedge i_mclk);
		chk({8'h00, o_rdata}, {8'h00, e});
	endtask
	// wait for the vector load, then check the program counter
	task automatic run_wait();
		for (waited = 0; waited < 12000; waited++) begin
			@(posedge i_mclk);
			if (o_pc_load === 1'b1) break;
		end
		if (waited == 12000) begin
			num_errors++;
			conclude();
		end else begin
			chk(o_pc, 16'h1234);
		end
	endtask
	task automatic dog();
		@(posedge i_mclk);
		i_wdt_timeout <= 1;
		@(posedge i_mclk);
		i_wdt_timeout <= 0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	// main sequence
	initial begin
		idle(5);
		i_reset_n <= 1;
		run_wait();
		rd(RSC_IDX_CLKCTL, 8'hA0);
		rd(RSC_IDX_CAUSE, 8'h80);
		rd(RSC_IDX_CAUSE, 8'h00);
		rd(RSC_IDX_DBGCTL, 8'h00);
		wr(RSC_IDX_STATE, 8'hFF);
		rd(RSC_IDX_STATE, 8'h00);
		$display("test power-on done");
		wr(RSC_IDX_CLKCTL, 8'h55);
		rd(RSC_IDX_CLKCTL, 8'h55);
		dog();
		run_wait();
		chk(waited >= RSC_HOLD_SHORT, 1);
		rd(RSC_IDX_CAUSE, 8'h20);
		rd(RSC_IDX_CLKCTL, 8'hA0);
		i_wdt_reset_sel <= 0;
		dog();
		@(posedge i_mclk);
		chk(o_wdt_irq, 1);
		chk(o_cpu_reset, 0);
		$display("test watchdog done");
		@(posedge i_mclk);
		i_wdt_reset_sel <= 1;
		board_low <= 1;
		idle(3);
		board_low <= 0;
		idle(12);
		chk(o_cpu_reset, 0);
		board_low <= 1;
		idle(120);
		chk(o_cpu_reset, 1);
		chk(o_gpio_reset, 1);
		chk(o_rst_pin_oe, 0);
		board_low <= 0;
		run_wait();
		rd(RSC_IDX_CAUSE, 8'h10);
		$display("test pin done");
		wr(RSC_IDX_CAUSE, 8'h3C);
		wr(RSC_IDX_CLKCTL, 8'h55);
		wr(RSC_IDX_DBGCTL, 8'h02);
		@(posedge i_mclk);
		i_stop_mode <= 1;
		i_gpio <= 8'h01;
		idle(20);
		chk(o_cpu_reset, 1);
		chk(o_periph_reset, 0);
		chk(o_brownout_en, 0);
		i_stop_mode <= 0;
		run_wait();
		chk(o_watchdog_control_reg, 8'h00);
		rd(RSC_IDX_CAUSE, 8'h40);
		rd(RSC_IDX_CLKCTL, 8'hA0);
		rd(RSC_IDX_DBGCTL, 8'h02);
		$display("test stop recovery done");
		wr(RSC_IDX_DBGCTL, 8'h03);
		idle(5);
		chk(o_dbg_keep, 1);
		chk(o_periph_reset, 1);
		chk(o_rst_pin_oe, 1);
		run_wait();
		rd(RSC_IDX_DBGCTL, 8'h00);
		rd(RSC_IDX_CAUSE, 8'h80);
		$display("test debugger done");
		i_por_n <= 0;
		i_brownout <= 1;
		i_supply_ok <= 0;
		idle(10);
		i_por_n <= 1;
		i_brownout <= 0;
		idle(200);
		rd(RSC_IDX_STATE, 8'h01);
		chk(o_cpu_reset, 1);
		i_supply_ok <= 1;
		run_wait();
		rd(RSC_IDX_CAUSE, 8'h80);
		$display("test brownout done");
		i_xtal_en <= 1;
		dog();
		run_wait();
		chk(waited >= HOLD_L, 1);
		$display("test crystal hold done");
		conclude();
	end
endmodule

bind rsc_ctrl rsc_props #(.HOLD_LONG(HOLD_LONG)) u_props (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
	.i_por_n(i_por_n), .i_brownout(i_brownout), .i_stop_mode(i_stop_mode), .i_wdt_timeout(i_wdt_timeout),
	.i_wdt_reset_sel(i_wdt_reset_sel), .i_xtal_en(i_xtal_en), .i_rst_pin(i_rst_pin),
	.i_pin_reset_en(i_pin_reset_en), .o_cpu_reset(o_cpu_reset), .o_periph_reset(o_periph_reset),
	.o_rst_pin_oe(o_rst_pin_oe), .o_rst_pin_out(o_rst_pin_out), .o_gpio_reset(o_gpio_reset),
	.o_wdt_irq(o_wdt_irq), .o_pc_load(o_pc_load), .o_clk_ctl(o_clk_ctl));
